// ==== atx_dma.sv ====
// Instruction-driven DMA from two converters into XRAM, with its FIFO
`timescale 1ns/1ps

// ----------------------------------------
// Small FIFO between converter buffers and XRAM
// ----------------------------------------
module atx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q, rd_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	// Extra pointer bit tells full from empty
	assign empty = (wr_q == rd_q);
	assign in_ready = ~((wr_q[AW-1:0] == rd_q[AW-1:0]) & (wr_q[AW] != rd_q[AW]));
	assign out_valid = ~empty;
	assign out_data = mem[rd_q[AW-1:0]];
	// Pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
	// Storage needs no reset
	always_ff @(posedge clk) begin
		if (push) mem[wr_q[AW-1:0]] <= in_data;
	end
endmodule

// ----------------------------------------
// DMA control, status and data path
// ----------------------------------------
module atx_dma (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Special function register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// Converter results
	input wire logic FIRST_CONVERTER_DONE,
	input wire logic [15:0] FIRST_CONVERTER_RESULT,
	input wire logic SECOND_CONVERTER_DONE,
	input wire logic [15:0] SECOND_CONVERTER_RESULT,
	// XRAM write port
	output logic XRAM_VALID,
	input wire logic XRAM_READY,
	output logic [15:0] XRAM_ADDR,
	output logic [15:0] XRAM_DATA,
	output logic XRAM_OFFCHIP,
	// Interrupt request
	output logic DMA_IRQ
);
	localparam int IDXW = atx_pkg::IDX_W;
	atx_pkg::atx_state_t st_q;
	logic [7:0] instr_mem [64];
	logic [7:0] instr_q;
	logic [IDXW-1:0] ipt_q, bnd_q, isw_q;
	logic [7:0] dal_q, dah_q, ctl_q, cth_q, ctrl_rd, cfg_rd;
	logic [15:0] ptr_q, rep_q;
	logic mode_q, wen_q, halt_q, cie_q, eoe_q;
	logic opc_q, ci_q, eo_q, irq_q;
	logic [1:0] warn_q, err_q, need_q, warn_set, err_set, pop, cap_en, done;
	logic [15:0] result [2];
	logic [15:0] buf_q [2];
	logic [1:0] bval_q;
	atx_pkg::atx_xfer_t push_x, head_x;
	logic fifo_ready, fifo_empty, head_valid;

	// Every check in this block runs on the system clock and sleeps through reset
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	// Address match, used for reads and writes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Register port decode
	wire wr_ctrl = SFR_WR & hit(SFR_ADDR, atx_pkg::OFS_CTRL);
	wire wr_cfg = SFR_WR & hit(SFR_ADDR, atx_pkg::OFS_CFG);
	wire acc_idt = (SFR_WR | SFR_RD) & hit(SFR_ADDR, atx_pkg::OFS_IDT);
	wire busy = (st_q != atx_pkg::ST_IDLE);
	wire start = wr_ctrl & SFR_WDATA[atx_pkg::B_RUN] & ~busy;
	wire stop = wr_ctrl & ~SFR_WDATA[atx_pkg::B_RUN];

	// Instruction fields; differential rides on the first converter's port
	wire i_continuous_conversion = instr_q[atx_pkg::B_CONTINUOUS_CONVERSION];
	wire i_need0 = instr_q[atx_pkg::B_DIFF] | instr_q[atx_pkg::B_FIRST];
	wire i_need1 = instr_q[atx_pkg::B_SEC];
	wire [7:0] mem_word = instr_mem[isw_q];
	wire mem_need0 = mem_word[atx_pkg::B_DIFF] | mem_word[atx_pkg::B_FIRST];
	wire mem_need1 = mem_word[atx_pkg::B_SEC];
	wire fetched_eop = ~(mem_need0 | mem_need1);
	wire [15:0] rep_dec = rep_q - atx_pkg::REP_ONE;
	wire rep_end = (rep_q == atx_pkg::REP_ONE);

	// Buffer to FIFO selection, first converter wins a tie
	assign pop[0] = bval_q[0] & need_q[0] & fifo_ready;
	assign pop[1] = bval_q[1] & need_q[1] & fifo_ready & ~pop[0];
	assign push_x.addr = ptr_q;
	assign push_x.data = pop[0] ? buf_q[0] : buf_q[1];
	assign done = {SECOND_CONVERTER_DONE, FIRST_CONVERTER_DONE};
	assign result[0] = FIRST_CONVERTER_RESULT;
	assign result[1] = SECOND_CONVERTER_RESULT;
	assign cap_en = (st_q == atx_pkg::ST_WAIT) ? need_q : 2'b00;

	// ----------------------------------------
	// Double-buffered converter paths
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_conv
			logic [15:0] dreg_q;
			logic dpend_q;
			wire arrive = done[gi] & cap_en[gi];
			// Overflow detection on a fresh result
			assign warn_set[gi] = arrive & bval_q[gi] & ~pop[gi] & ~dpend_q;
			assign err_set[gi] = arrive & bval_q[gi] & ~pop[gi] & dpend_q;
			// Buffer takes a result only once its previous word has left
			always_ff @(posedge CLK_SYS) begin
				if (!RESETN || !busy) begin
					bval_q[gi] <= 1'b0;
					dpend_q <= 1'b0;
					buf_q[gi] <= '0;
					dreg_q <= '0;
				end else if (arrive && (!bval_q[gi] || (pop[gi] && !dpend_q))) begin
					buf_q[gi] <= result[gi];
					bval_q[gi] <= 1'b1;
				end else if (arrive && pop[gi]) begin
					buf_q[gi] <= dreg_q;
					dreg_q <= result[gi];
				end else if (arrive) begin
					dreg_q <= result[gi];
					dpend_q <= 1'b1;
				end else if (pop[gi]) begin
					bval_q[gi] <= dpend_q;
					buf_q[gi] <= dreg_q;
					dpend_q <= 1'b0;
				end
			end
			a_err_on_loss: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
				arrive && bval_q[gi] && !pop[gi] && dpend_q && !wr_ctrl |=> err_q[gi])
				else $error("error flag missed a lost result");
			a_warn_on_full: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
				arrive && bval_q[gi] && !pop[gi] && !dpend_q |=> warn_q[gi])
				else $error("warning flag missed a full buffer");
		end
	endgenerate

	// ----------------------------------------
	// FIFO and XRAM port
	// ----------------------------------------
	atx_fifo #(.WIDTH($bits(atx_pkg::atx_xfer_t)), .DEPTH(atx_pkg::FIFO_DEPTH)) u_fifo (
		.clk(CLK_SYS),
		.rst_n(RESETN),
		.in_valid(pop[0] | pop[1]),
		.in_ready(fifo_ready),
		.in_data(push_x),
		.out_valid(head_valid),
		.out_ready(XRAM_READY & XRAM_VALID),
		.out_data(head_x),
		.empty(fifo_empty)
	);
	// Off-chip writes stall while the core owns the external bus
	assign XRAM_OFFCHIP = (head_x.addr >= atx_pkg::ONCHIP_TOP);
	assign XRAM_VALID = head_valid & ~(XRAM_OFFCHIP & halt_q);
	assign XRAM_ADDR = head_x.addr;
	assign XRAM_DATA = head_x.data;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			st_q <= atx_pkg::ST_IDLE;
			isw_q <= '0;
			instr_q <= atx_pkg::RST_BYTE;
			need_q <= 2'b00;
			rep_q <= '0;
			ptr_q <= '0;
		end else if (start) begin
			st_q <= atx_pkg::ST_FETCH;
			isw_q <= bnd_q;
			rep_q <= {cth_q, ctl_q};
			ptr_q <= {dah_q, dal_q};
		end else if (stop) begin
			st_q <= atx_pkg::ST_IDLE;
			// A word pushed in the stop cycle still lands, so the pointer must follow it
			if (pop[0] | pop[1]) ptr_q <= ptr_q + atx_pkg::PTR_STEP;
		end else begin
			if (pop[0] | pop[1]) ptr_q <= ptr_q + atx_pkg::PTR_STEP;
			need_q <= need_q & ~pop;
			case (st_q)
				atx_pkg::ST_FETCH: begin
					instr_q <= mem_word;
					need_q <= {mem_need1, mem_need0};
					if (!fetched_eop) begin
						st_q <= atx_pkg::ST_WAIT;
					end else begin
						isw_q <= bnd_q;
						if (mem_word[atx_pkg::B_CONTINUOUS_CONVERSION]) st_q <= atx_pkg::ST_FETCH;
						else if (mode_q || rep_end) st_q <= atx_pkg::ST_DRAIN;
						else rep_q <= rep_dec;
					end
				end
				atx_pkg::ST_WAIT: begin
					if (need_q == 2'b00) st_q <= atx_pkg::ST_NEXT;
				end
				atx_pkg::ST_NEXT: begin
					st_q <= atx_pkg::ST_FETCH;
					if (!mode_q) begin
						isw_q <= isw_q + 1'b1;
					end else if (!i_continuous_conversion) begin
						rep_q <= rep_end ? {cth_q, ctl_q} : rep_dec;
						if (rep_end) isw_q <= isw_q + 1'b1;
					end
				end
				atx_pkg::ST_DRAIN: begin
					if (fifo_empty) st_q <= atx_pkg::ST_IDLE;
				end
				default: st_q <= atx_pkg::ST_IDLE;
			endcase
		end
	end

	// Event strobes feeding the sticky flags
	wire ev_eop = (st_q == atx_pkg::ST_FETCH) & fetched_eop & ~stop & ~start;
	wire ev_rep_fetch = ev_eop & ~mem_word[atx_pkg::B_CONTINUOUS_CONVERSION] & ~mode_q & rep_end;
	wire ev_rep_next = (st_q == atx_pkg::ST_NEXT) & mode_q & ~i_continuous_conversion & rep_end & ~stop;
	wire ev_rep = ev_rep_fetch | ev_rep_next;
	wire ev_done = (st_q == atx_pkg::ST_DRAIN) & fifo_empty & ~stop;

	// Sticky flag update: a set wins over a software clear
	function automatic logic sticky(input logic q, input logic set, input logic wr, input logic wbit);
		return set | (q & ~(wr & ~wbit));
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			{mode_q, wen_q, halt_q, cie_q, eoe_q} <= '0;
			{opc_q, ci_q, eo_q, irq_q} <= '0;
			warn_q <= 2'b00;
			err_q <= 2'b00;
			{dal_q, dah_q, ctl_q, cth_q} <= '0;
			ipt_q <= '0;
			bnd_q <= '0;
		end else begin
			opc_q <= sticky(opc_q, ev_done, wr_ctrl, SFR_WDATA[atx_pkg::B_OPC]);
			err_q[1] <= sticky(err_q[1], err_set[1], wr_ctrl, SFR_WDATA[atx_pkg::B_ERR1]);
			err_q[0] <= sticky(err_q[0], err_set[0], wr_ctrl, SFR_WDATA[atx_pkg::B_ERR0]);
			warn_q[1] <= sticky(warn_q[1], warn_set[1], wr_ctrl, SFR_WDATA[atx_pkg::B_WARN1]);
			warn_q[0] <= sticky(warn_q[0], warn_set[0], wr_ctrl, SFR_WDATA[atx_pkg::B_WARN0]);
			ci_q <= sticky(ci_q, ev_rep, wr_cfg, SFR_WDATA[atx_pkg::B_CI]);
			eo_q <= sticky(eo_q, ev_eop, wr_cfg, SFR_WDATA[atx_pkg::B_EO]);
			irq_q <= opc_q | (|err_q) | (wen_q & (|warn_q)) | (cie_q & ci_q) | (eoe_q & eo_q);
			if (wr_ctrl) begin
				mode_q <= SFR_WDATA[atx_pkg::B_MODE];
				wen_q <= SFR_WDATA[atx_pkg::B_WEN];
			end
			if (wr_cfg) begin
				halt_q <= SFR_WDATA[atx_pkg::B_HALT];
				cie_q <= SFR_WDATA[atx_pkg::B_CIE];
				eoe_q <= SFR_WDATA[atx_pkg::B_EOE];
			end
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_DAL)) dal_q <= SFR_WDATA;
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_DAH)) dah_q <= SFR_WDATA;
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_CTL)) ctl_q <= SFR_WDATA;
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_CTH)) cth_q <= SFR_WDATA;
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_BND)) bnd_q <= SFR_WDATA[IDXW-1:0];
			if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_IPT)) ipt_q <= SFR_WDATA[IDXW-1:0];
			else if (acc_idt) ipt_q <= ipt_q + 1'b1;
		end
	end
	assign DMA_IRQ = irq_q;

	// Instruction RAM has no reset, so reads before a write are undefined
	always_ff @(posedge CLK_SYS) begin
		if (SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_IDT)) instr_mem[ipt_q] <= SFR_WDATA;
	end

	// Read data; reserved configuration bits always read zero
	assign ctrl_rd = {busy, opc_q, mode_q, err_q, wen_q, warn_q};
	assign cfg_rd = {halt_q, XRAM_VALID & XRAM_OFFCHIP, 2'b00, cie_q, ci_q, eoe_q, eo_q};
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			SFR_RDATA <= atx_pkg::RST_BYTE;
		end else if (SFR_RD) begin
			case (SFR_ADDR)
				atx_pkg::OFS_CTRL: SFR_RDATA <= ctrl_rd;
				atx_pkg::OFS_CFG: SFR_RDATA <= cfg_rd;
				atx_pkg::OFS_DAL: SFR_RDATA <= dal_q;
				atx_pkg::OFS_DAH: SFR_RDATA <= dah_q;
				atx_pkg::OFS_DSL: SFR_RDATA <= ptr_q[7:0];
				atx_pkg::OFS_DSH: SFR_RDATA <= ptr_q[15:8];
				atx_pkg::OFS_IPT: SFR_RDATA <= {2'b00, ipt_q};
				atx_pkg::OFS_IDT: SFR_RDATA <= instr_mem[ipt_q];
				atx_pkg::OFS_CTL: SFR_RDATA <= ctl_q;
				atx_pkg::OFS_CTH: SFR_RDATA <= cth_q;
				atx_pkg::OFS_CSL: SFR_RDATA <= rep_q[7:0];
				atx_pkg::OFS_CSH: SFR_RDATA <= rep_q[15:8];
				atx_pkg::OFS_BND: SFR_RDATA <= {2'b00, bnd_q};
				default: SFR_RDATA <= atx_pkg::RST_BYTE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start_wr;
		start;
	endsequence
	sequence s_running;
		busy ##1 busy;
	endsequence
	a_run_start: assert property (s_start_wr |=> s_running and (isw_q == bnd_q))
		else $error("start did not load the boundary and run");
	a_run_stop: assert property (stop |=> !busy)
		else $error("stop did not idle the engine");
	a_ipt_step: assert property (acc_idt && !(SFR_WR && hit(SFR_ADDR, atx_pkg::OFS_IPT))
		|=> ipt_q == $past(ipt_q) + 1'b1)
		else $error("buffer index did not step");
	a_ptr_step: assert property ((pop[0] | pop[1]) && !start |=> ptr_q == $past(ptr_q) + atx_pkg::PTR_STEP)
		else $error("write pointer did not step by one word");
	a_halt_hold: assert property (halt_q && head_valid && XRAM_OFFCHIP
		|-> !XRAM_VALID ##1 (head_valid && $stable(XRAM_ADDR) && $stable(XRAM_DATA)))
		else $error("off-chip word sent or dropped while core owns the bus");
	a_warn_gate: assert property (!wen_q && !opc_q && err_q == 2'b00 && !ci_q && !eo_q
		|=> !DMA_IRQ)
		else $error("interrupt without an enabled source");
	a_err_irq: assert property (|err_q |=> DMA_IRQ)
		else $error("error flag did not interrupt");
	a_eop_flag: assert property (ev_eop |=> eo_q ##1 (eo_q || $past(wr_cfg)))
		else $error("end-of-operation flag missed");
	a_done_flag: assert property (ev_done |=> opc_q && !busy)
		else $error("complete flag missed on idle");
	// Waiting bits never name a converter that the running instruction left out
	a_need_sub: assert property (st_q == atx_pkg::ST_WAIT |-> (need_q & ~{i_need1, i_need0}) == 2'b00)
		else $error("waiting on a converter the instruction did not name");
	a_continuous_conversion_loop: assert property (st_q == atx_pkg::ST_FETCH && fetched_eop
		&& mem_word[atx_pkg::B_CONTINUOUS_CONVERSION] && !stop |=> st_q == atx_pkg::ST_FETCH && isw_q == $past(bnd_q))
		else $error("continuous list did not wrap to the boundary");
	a_busy_read: assert property (SFR_RD && hit(SFR_ADDR, atx_pkg::OFS_CFG)
		|=> SFR_RDATA[atx_pkg::B_XBY] == $past(XRAM_VALID && XRAM_OFFCHIP))
		else $error("off-chip busy bit misread");
endmodule

// ==== atx_pkg.sv ====
// Constants and types for the ADC-to-XRAM DMA control block
// How it works
// - Any enabled interrupt condition raises the single DMA interrupt request.
// - Operations-complete flag sets once all work is done and engine idle; sticky.
// - Second converter error flag sets when a result is lost; sticky.
// - First converter error flag sets when a result is lost; sticky.
// - Second converter warning sets when result arrives with buffer still full.
// - First converter warning sets when result arrives with buffer still full.
// - Warning flags interrupt only while the shared warning enable is set.
// - Repeat-overflow flag sets at end of count; interrupts if its enable set.
// - End-of-operation flag sets on an end instruction; interrupts if enabled.
// - Each converter path is double-buffered; buffer drains at first chance.
// - No copy into a buffer until its old word has gone out.
// - Second result while buffer full overwrites data register and flags error.
// - Run bit write 1 starts, 0 stops; reads 1 while busy.
// - Mode bit selects sequencing mode 0 or mode 1.
// - Handoff bit 1 gives off-chip XRAM to the core; off-chip writes wait.
// - Off-chip busy bit reads 1 during a DMA off-chip access; read-only.
// - Buffer index is 6 bits and steps after each data port access.
// - Instruction bits: continuous, differential, second, first; low nibble zero.
// - Differential plus first-converter stores only the differential word.
// - Continuous bit ignores the repeat counter and runs on.
// - Start boundary holds the 6-bit first instruction address.
// - Instruction RAM is not reset; contents undefined until written.
// - Write pointer loads from start address at enable, steps 2 per word.
// - Repeat counter loads from the limit at operation start.
package atx_pkg;
	// Register offsets on the special function register port
	localparam logic [7:0] OFS_CTRL = 8'hD8;
	localparam logic [7:0] OFS_DAL = 8'hD9;
	localparam logic [7:0] OFS_DAH = 8'hDA;
	localparam logic [7:0] OFS_DSL = 8'hDB;
	localparam logic [7:0] OFS_DSH = 8'hDC;
	localparam logic [7:0] OFS_IPT = 8'hDD;
	localparam logic [7:0] OFS_IDT = 8'hDE;
	localparam logic [7:0] OFS_CFG = 8'hF8;
	localparam logic [7:0] OFS_CTL = 8'hF9;
	localparam logic [7:0] OFS_CTH = 8'hFA;
	localparam logic [7:0] OFS_CSL = 8'hFB;
	localparam logic [7:0] OFS_CSH = 8'hFC;
	localparam logic [7:0] OFS_BND = 8'hFD;
	// Control register bits
	localparam int B_RUN = 7;
	localparam int B_OPC = 6;
	localparam int B_MODE = 5;
	localparam int B_ERR1 = 4;
	localparam int B_ERR0 = 3;
	localparam int B_WEN = 2;
	localparam int B_WARN1 = 1;
	localparam int B_WARN0 = 0;
	// Configuration register bits
	localparam int B_HALT = 7;
	localparam int B_XBY = 6;
	localparam int B_CIE = 3;
	localparam int B_CI = 2;
	localparam int B_EOE = 1;
	localparam int B_EO = 0;
	// Instruction word bits
	localparam int B_CONTINUOUS_CONVERSION = 7;
	localparam int B_DIFF = 6;
	localparam int B_SEC = 5;
	localparam int B_FIRST = 4;
	// Sizes, steps and reset values
	localparam int IDX_W = 6;
	localparam int FIFO_DEPTH = 4;
	localparam logic [15:0] PTR_STEP = 16'h0002;
	localparam logic [15:0] REP_ONE = 16'h0001;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] ONCHIP_TOP = 16'h1000;
	// One XRAM word write
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} atx_xfer_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WAIT,
		ST_NEXT,
		ST_DRAIN
	} atx_state_t;
endpackage

// ==== atx_xram_model.sv ====
// Behavioural XRAM write target that answers the DMA block's write port
`timescale 1ns/1ps

module atx_xram_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write port from the DMA
	input wire logic valid,
	output logic ready,
	input wire logic [15:0] addr,
	input wire logic [15:0] data,
	// Bench control: stall holds every word, slow accepts on alternate cycles
	input wire logic stall,
	input wire logic slow
);
	logic [15:0] wa [0:255];
	logic [15:0] wd [0:255];
	int count = 0;
	logic tgl = 1'b0;

	// Ready pattern; a stalled memory never accepts, as when the core owns it
	assign ready = ~stall & (~slow | tgl);

	// Record every accepted word in arrival order
	always @(posedge clk) begin
		tgl <= ~tgl;
		if (rst_n && valid && ready) begin
			wa[count] <= addr;
			wd[count] <= data;
			count <= count + 1;
		end
	end
endmodule

// ==== adc_to_xram_dma_status_control_tb.sv ====
// Self-checking bench for the ADC-to-XRAM DMA control block
`timescale 1ns/1ps

module adc_to_xram_dma_status_control_tb;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic CLK_SYS = 1'b0;
	logic RESETN = 1'b0;
	logic [7:0] SFR_ADDR = 8'h00;
	logic SFR_WR = 1'b0;
	logic SFR_RD = 1'b0;
	logic [7:0] SFR_WDATA = 8'h00;
	logic [7:0] SFR_RDATA;
	logic FIRST_CONVERTER_DONE = 1'b0;
	logic [15:0] FIRST_CONVERTER_RESULT = 16'h0000;
	logic SECOND_CONVERTER_DONE = 1'b0;
	logic [15:0] SECOND_CONVERTER_RESULT = 16'h0000;
	logic XRAM_VALID;
	logic XRAM_READY;
	logic [15:0] XRAM_ADDR;
	logic [15:0] XRAM_DATA;
	logic XRAM_OFFCHIP;
	logic DMA_IRQ;
	logic stall = 1'b0;
	logic slow = 1'b0;
	int failures = 0;
	int checked = 0;
	int base = 0;
	logic [7:0] rd;

	// 25 MHz system clock
	always #20 CLK_SYS = ~CLK_SYS;

	atx_dma atx_dma_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
		.SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .FIRST_CONVERTER_DONE(FIRST_CONVERTER_DONE),
		.FIRST_CONVERTER_RESULT(FIRST_CONVERTER_RESULT), .SECOND_CONVERTER_DONE(SECOND_CONVERTER_DONE), .SECOND_CONVERTER_RESULT(SECOND_CONVERTER_RESULT),
		.XRAM_VALID(XRAM_VALID), .XRAM_READY(XRAM_READY), .XRAM_ADDR(XRAM_ADDR), .XRAM_DATA(XRAM_DATA),
		.XRAM_OFFCHIP(XRAM_OFFCHIP), .DMA_IRQ(DMA_IRQ));
	atx_xram_model atx_xram_model_inst (.clk(CLK_SYS), .rst_n(RESETN), .valid(XRAM_VALID),
		.ready(XRAM_READY), .addr(XRAM_ADDR), .data(XRAM_DATA), .stall(stall), .slow(slow));

	// ----------------------------------------
	// Compare, bus and stimulus tasks
	// ----------------------------------------
	task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Register strobes are one-cycle pulses launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK_SYS);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1'b1;
		@(negedge CLK_SYS);
		SFR_WR = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(negedge CLK_SYS);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		@(negedge CLK_SYS);
		SFR_RD = 1'b0;
		rd = SFR_RDATA;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask
	// One conversion result; the data lines show garbage outside the pulse
	task automatic pulse(input bit which, input logic [15:0] v);
		@(negedge CLK_SYS);
		FIRST_CONVERTER_RESULT = v;
		SECOND_CONVERTER_RESULT = v;
		FIRST_CONVERTER_DONE = !which;
		SECOND_CONVERTER_DONE = which;
		@(negedge CLK_SYS);
		FIRST_CONVERTER_DONE = 1'b0;
		SECOND_CONVERTER_DONE = 1'b0;
		FIRST_CONVERTER_RESULT = ~v;
		SECOND_CONVERTER_RESULT = ~v;
		wait_cyc(10);
	endtask
	// Poll the run bit under a bounded count
	task automatic wait_idle();
		int n = 0;
		rd = 8'h80;
		while (rd[7] !== 1'b0 && n < 60) begin
			rd_reg(atx_pkg::OFS_CTRL);
			n++;
		end
		check_reg("run bit idle", 8'h00, {7'h00, rd[7]});
	endtask
	task automatic prog(input logic [7:0] p, input logic [7:0] i0, input logic [7:0] i1, input logic [7:0] i2);
		wr(atx_pkg::OFS_IPT, p);
		wr(atx_pkg::OFS_IDT, i0);
		wr(atx_pkg::OFS_IDT, i1);
		wr(atx_pkg::OFS_IDT, i2);
		rd_reg(atx_pkg::OFS_IPT);
		check_reg("index after load", p + 8'h03, rd);
		wr(atx_pkg::OFS_BND, p);
	endtask
	task automatic launch(input logic [7:0] dah, input logic [7:0] lim, input logic [7:0] ctrl);
		wr(atx_pkg::OFS_DAH, dah);
		wr(atx_pkg::OFS_DAL, 8'h00);
		wr(atx_pkg::OFS_CTL, lim);
		wr(atx_pkg::OFS_CTH, 8'h00);
		base = atx_xram_model_inst.count;
		wr(atx_pkg::OFS_CTRL, ctrl);
	endtask
	task automatic check_irq(input logic exp);
		wait_cyc(3);
		check_reg("irq", {7'h00, exp}, {7'h00, DMA_IRQ});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd_reg(atx_pkg::OFS_CTRL);
		check_reg("control reset", 8'h00, rd);
		rd_reg(atx_pkg::OFS_CFG);
		check_reg("config reset", 8'h00, rd);
		rd_reg(atx_pkg::OFS_BND);
		check_reg("boundary reset", 8'h00, rd);
		rd_reg(8'h00);
		check_reg("unmapped", 8'h00, rd);
		wr(atx_pkg::OFS_DAH, 8'hA5);
		rd_reg(atx_pkg::OFS_DAH);
		check_reg("start high", 8'hA5, rd);
		wr(atx_pkg::OFS_IPT, 8'hFF);
		rd_reg(atx_pkg::OFS_IPT);
		check_reg("index width", 8'h3F, rd);
		wr(atx_pkg::OFS_IDT, 8'h5A);
		wr(atx_pkg::OFS_IPT, 8'h3F);
		rd_reg(atx_pkg::OFS_IDT);
		check_reg("buffer readback", 8'h5A, rd);
		rd_reg(atx_pkg::OFS_IPT);
		check_reg("index wrap", 8'h00, rd);
		check_irq(1'b0);
	endtask
	// Program differential, second: mode 0 runs the list twice, mode 1 repeats each step
	task automatic t_seq(input bit mode);
		int k;
		logic [15:0] e;
		prog(8'h08, 8'h50, 8'h20, 8'h00);
		wr(atx_pkg::OFS_CFG, 8'h0A);
		slow = mode;
		launch(8'h08, 8'h02, {2'b10, mode, 5'h00});
		for (k = 0; k < 3; k++) begin
			pulse(1'b0, 16'hA000 + 16'(k));
			pulse(1'b1, 16'hB000 + 16'(k));
		end
		wait_idle();
		check_word("word count", 16'h0004, 16'(atx_xram_model_inst.count - base));
		for (k = 0; k < 4; k++) begin
			if (mode)
				e = (k < 2) ? 16'hA000 + 16'(k) : 16'hB000 + 16'(k - 1);
			else
				e = (k[0] ? 16'hB000 : 16'hA000) + 16'(k / 2);
			check_word("xram data", e, atx_xram_model_inst.wd[base + k]);
			check_word("xram addr", 16'h0800 + 16'(2 * k), atx_xram_model_inst.wa[base + k]);
		end
		rd_reg(atx_pkg::OFS_CTRL);
		check_reg("control after run", {2'b01, mode, 5'h00}, rd);
		rd_reg(atx_pkg::OFS_CFG);
		check_reg("config after run", 8'h0F, rd);
		check_irq(1'b1);
		wr(atx_pkg::OFS_CTRL, {2'b00, mode, 5'h00});
		wr(atx_pkg::OFS_CFG, 8'h05);
		check_irq(1'b0);
		wr(atx_pkg::OFS_CFG, 8'h0D);
		check_irq(1'b1);
		wr(atx_pkg::OFS_CFG, 8'h00);
		slow = 1'b0;
	endtask
	// Memory stalled under a continuous list: the buffer fills, then warns, then loses data
	task automatic t_overflow();
		int k;
		prog(8'h00, 8'h90, 8'h80, 8'h00);
		stall = 1'b1;
		launch(8'h00, 8'h01, 8'h80);
		for (k = 0; k < 10; k++)
			pulse(1'b0, 16'hC000 + 16'(k));
		rd_reg(atx_pkg::OFS_CTRL);
		check_reg("overflow bits", 8'h89, rd & 8'h9B);
		check_irq(1'b1);
		wr(atx_pkg::OFS_CTRL, 8'h01);
		check_irq(1'b0);
		wr(atx_pkg::OFS_CTRL, 8'h05);
		check_irq(1'b1);
		wr(atx_pkg::OFS_CTRL, 8'h00);
		wr(atx_pkg::OFS_CFG, 8'h00);
		stall = 1'b0;
		wait_cyc(20);
		rd_reg(atx_pkg::OFS_CTRL);
		check_reg("stopped control", 8'h00, rd);
	endtask
	// Off-chip word waits for the handoff bit, then shows busy while it stands
	task automatic t_halt();
		prog(8'h10, 8'h10, 8'h00, 8'h00);
		wr(atx_pkg::OFS_CFG, 8'h80);
		launch(8'h20, 8'h01, 8'h80);
		pulse(1'b0, 16'h1234);
		check_word("held writes", 16'h0000, 16'(atx_xram_model_inst.count - base));
		check_reg("valid held", 8'h00, {7'h00, XRAM_VALID});
		stall = 1'b1;
		wr(atx_pkg::OFS_CFG, 8'h00);
		wait_cyc(2);
		rd_reg(atx_pkg::OFS_CFG);
		check_reg("busy bit", 8'h40, rd & 8'h40);
		check_reg("offchip flag", 8'h01, {7'h00, XRAM_OFFCHIP});
		stall = 1'b0;
		wait_idle();
		check_word("offchip count", 16'h0001, 16'(atx_xram_model_inst.count - base));
		check_word("offchip addr", 16'h2000, atx_xram_model_inst.wa[base]);
		check_word("offchip data", 16'h1234, atx_xram_model_inst.wd[base]);
		rd_reg(atx_pkg::OFS_CFG);
		check_reg("busy clear", 8'h00, rd & 8'h40);
	endtask

	// ----------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence after an 8-cycle reset
	initial begin
		wait_cyc(8);
		RESETN = 1'b1;
		t_regs();
		t_seq(1'b0);
		t_seq(1'b1);
		t_overflow();
		t_halt();
		print_verdict();
	end
	// Whole run needs a few hundred cycles; this margin only cuts a hang
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		failures++;
		print_verdict();
	end
endmodule
